// [verilog/readout_ctrl_pkg.sv]
// Package with register map, field layouts and timing of the sequencer control block
package readout_ctrl_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam logic [7:0] REG_CTRL        = 8'h00;
  localparam logic [7:0] REG_DELAY       = 8'h04;
  localparam logic [7:0] REG_VALID_CFG   = 8'h08;
  localparam logic [7:0] REG_PROG_LEN    = 8'h0C;
  localparam logic [7:0] REG_PROG_DATA   = 8'h10;
  localparam logic [7:0] REG_PROGRESS    = 8'h14;
  localparam logic [7:0] REG_MEM_USAGE   = 8'h18;
  localparam logic [7:0] REG_SEQ_STATUS  = 8'h1C;
  localparam logic [7:0] REG_LOG_CFG     = 8'h20;
  localparam logic [7:0] REG_LOG_START   = 8'h24;
  localparam logic [7:0] REG_LOG_STATUS  = 8'h28;
  localparam logic [7:0] REG_LOG_RD_ADDR = 8'h2C;
  localparam logic [7:0] REG_LOG_RD_DATA = 8'h30;
  localparam logic [7:0] REG_LOG_RD_TIME = 8'h34;
  localparam logic [7:0] REG_USER_BASE   = 8'h40;
  // Control register bit positions
  localparam int CTRL_ENABLE    = 0;
  localparam int CTRL_SINGLE    = 1;
  localparam int CTRL_PIPE      = 2;
  localparam int CTRL_CLRWAVE   = 3;
  localparam int CTRL_SEQRESET  = 4;
  localparam int CTRL_LOGCLEAR  = 5;
  localparam int CTRL_READY     = 8;
  localparam int CTRL_TRIGGERED = 9;
  // Log config bits
  localparam int LOGCFG_ENABLE = 0;
  localparam int LOGCFG_SOURCE = 1;
  localparam int LOGCFG_MODE   = 2;
  // Status word bits
  localparam int ST_RUNNING   = 0;
  localparam int ST_WAIT_TRIG = 2;
  localparam int ST_ERROR     = 3;
  localparam int ST_WAIT_SYNC = 4;
  localparam int VPOL_LSB     = 8;
  localparam logic [1:0] VPOL_NONE = 2'h0;
  localparam logic [1:0] VPOL_LOW  = 2'h1;
  localparam logic [1:0] VPOL_HIGH = 2'h2;
  localparam logic [1:0] VPOL_BOTH = 2'h3;
  localparam logic [2:0] LOG_IDLE   = 3'h0;
  localparam logic [2:0] LOG_NORMAL = 3'h1;
  localparam logic [2:0] LOG_WAIT   = 3'h2;
  localparam logic [2:0] LOG_ACTIVE = 3'h3;
  localparam logic [2:0] LOG_FULL   = 3'h4;
  localparam int LOG_DEPTH  = 1024;
  localparam int IMEM_WORDS = 16384;
  localparam int DELAY_STEP_PS  = 2000;
  localparam int TIMEBASE_PS    = 4000;
  localparam int CLK_PERIOD_PS  = 100000;
  localparam int TICK_CYCLES = (TIMEBASE_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int NUM_SLOTS  = 8;
  localparam int NUM_USER   = 16;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic              wr;
    logic              rd;
  } bus_req_s;

  typedef struct packed {
    logic running;
    logic wait_trig;
    logic error;
    logic wait_sync;
    logic triggered;
  } seq_status_s;
endpackage : readout_ctrl_pkg

// [verilog/readout_sequencer_ctrl_logger.sv]
// Control, status and event logger for one readout sequencer channel
//
// Decided for this implementation: the strobed register port and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none
module readout_sequencer_ctrl_logger #(
  parameter int DIO_W  = 32,
  parameter int SYNC_W = 32,
  parameter int TS_W   = 32
) (
  input  wire logic                                i_core_clk,   // 10 MHz
  input  wire logic                                i_rst,        // Sync high
  input  wire readout_ctrl_pkg::bus_req_s          i_bus,        // Host bus
  output logic [readout_ctrl_pkg::DATA_W-1:0]      o_rdata,      // Read data
  input  wire logic [DIO_W-1:0]                    i_dio,        // I/O pins
  input  wire logic [SYNC_W-1:0]                   i_sync_word,  // Link word
  input  wire logic                                i_sync_vld,   // Link strobe
  input  wire readout_ctrl_pkg::seq_status_s       i_seq_status, // Core state
  input  wire logic                                i_seq_start,  // Run pulse
  input  wire logic                                i_user_we,    // Seq write
  input  wire logic [3:0]                          i_user_idx,   // Seq index
  input  wire logic [31:0]                         i_user_wdata, // Seq data
  output logic [31:0]                              o_user_rdata, // Seq data
  output logic                                     o_seq_enable, // Run enable
  output logic                                     o_seq_single, // Single shot
  output logic                                     o_seq_ready,  // Has program
  output logic                                     o_clear_wave, // Slot clear
  output logic [15:0]                              o_play_delay, // 2 ns units
  output logic                                     o_prog_we,    // Active store
  output logic                                     o_stage_we,   // Staging
  output logic [13:0]                              o_prog_addr,  // Word addr
  output logic [31:0]                              o_prog_data,  // Word
  output logic                                     o_dio_valid   // Qualified
);
  // Elaboration check: widths beyond one data word are not served
  if (DIO_W < 2 || DIO_W > 32 || SYNC_W > 32 || TS_W > 32) begin : g_bad_w
    $error("unsupported width");
  end

  localparam int LA = $clog2(readout_ctrl_pkg::LOG_DEPTH);

  // ==========================================================================
  // State
  typedef struct packed {
    logic                enable;
    logic                single;
    logic                pipe;
    logic                ready;
    logic                clear_wave;
    logic [15:0]         delay;
    logic [4:0]          vidx;
    logic [1:0]          vpol;
    logic [14:0]         prog_len;
    logic [14:0]         prog_cnt;
    logic                prog_we;
    logic                stage_we;
    logic [13:0]         prog_addr;
    logic [31:0]         prog_data;
    logic                log_en;
    logic                log_src;
    logic                log_mode;
    logic [TS_W-1:0]     start_ts;
    logic [2:0]          log_state;
    logic [LA-1:0]       wptr;
    logic [LA:0]         count;
    logic [TS_W-1:0]     ts;
    logic [LA-1:0]       rd_addr;
    logic [DIO_W-1:0]    dio_m;
    logic [DIO_W-1:0]    dio_q;
    logic                triggered;
    logic [31:0]         rdata;
  } st_s;

  st_s st_reg, st_next;
  logic [31:0] user_reg [readout_ctrl_pkg::NUM_USER];
  logic [31:0] log_data [readout_ctrl_pkg::LOG_DEPTH];
  logic [TS_W-1:0] log_time [readout_ctrl_pkg::LOG_DEPTH];
  logic        log_we;
  logic [31:0] log_word;

  function automatic logic valid_ok(input logic [1:0] pol, input logic bitv);
    unique case (pol)
      readout_ctrl_pkg::VPOL_NONE: valid_ok = 1'b1;
      readout_ctrl_pkg::VPOL_LOW:  valid_ok = ~bitv;
      readout_ctrl_pkg::VPOL_HIGH: valid_ok = bitv;
      default:                     valid_ok = 1'b1;
    endcase
  endfunction : valid_ok

  function automatic logic [31:0] pct(input logic [14:0] a,
                                      input logic [14:0] b);
    logic [31:0] p;
    p = 32'h0;
    if (b != 15'h0)
      p = (32'(a) * 32'd100) / 32'(b);
    pct = p;
  endfunction : pct

  logic wr_hit, rd_hit;
  logic [7:0] a;
  logic dio_bit;
  logic src_vld;
  assign a = i_bus.addr;
  assign dio_bit = st_reg.dio_q[st_reg.vidx[$clog2(DIO_W)-1:0]];
  // Qualified input present
  assign o_dio_valid = valid_ok(st_reg.vpol, dio_bit);
  assign src_vld = st_reg.log_src ? i_sync_vld : o_dio_valid;

  // ==========================================================================
  // Next state
  always_comb begin
    st_next = st_reg;
    st_next.clear_wave = 1'b0;
    st_next.prog_we = 1'b0;
    st_next.stage_we = 1'b0;
    st_next.dio_m = i_dio;
    st_next.dio_q = st_reg.dio_m;
    log_we = 1'b0;
    log_word = st_reg.log_src ? 32'(i_sync_word) : 32'(st_reg.dio_q);
    // Host writes; read-only addresses ignore writes
    if (i_bus.wr) begin
      unique case (a)
        readout_ctrl_pkg::REG_CTRL: begin
          st_next.enable = i_bus.wdata[readout_ctrl_pkg::CTRL_ENABLE] &
                           st_reg.ready;
          st_next.single = i_bus.wdata[readout_ctrl_pkg::CTRL_SINGLE];
          st_next.pipe   = i_bus.wdata[readout_ctrl_pkg::CTRL_PIPE];
          st_next.clear_wave = i_bus.wdata[readout_ctrl_pkg::CTRL_CLRWAVE];
          if (i_bus.wdata[readout_ctrl_pkg::CTRL_SEQRESET]) begin
            st_next.ready = 1'b0;
            st_next.enable = 1'b0;
            st_next.prog_cnt = 15'h0;
            st_next.prog_len = 15'h0;
            st_next.triggered = 1'b0;
          end
          if (i_bus.wdata[readout_ctrl_pkg::CTRL_LOGCLEAR]) begin
            st_next.count = '0;
            st_next.wptr = '0;
          end
        end
        readout_ctrl_pkg::REG_DELAY: st_next.delay = i_bus.wdata[15:0];
        readout_ctrl_pkg::REG_VALID_CFG: begin
          st_next.vidx = i_bus.wdata[4:0];
          st_next.vpol = i_bus.wdata[readout_ctrl_pkg::VPOL_LSB +: 2];
        end
        readout_ctrl_pkg::REG_PROG_LEN: begin
          st_next.prog_len = i_bus.wdata[14:0];
          st_next.prog_cnt = 15'h0;
          st_next.ready = 1'b0;
        end
        readout_ctrl_pkg::REG_PROG_DATA: begin
          if (st_reg.prog_cnt < st_reg.prog_len &&
              st_reg.prog_cnt < 15'(readout_ctrl_pkg::IMEM_WORDS)) begin
            st_next.prog_addr = st_reg.prog_cnt[13:0];
            st_next.prog_data = i_bus.wdata;
            st_next.stage_we = st_reg.pipe;
            st_next.prog_we = ~st_reg.pipe;
            st_next.prog_cnt = st_reg.prog_cnt + 15'h1;
            if (st_reg.prog_cnt + 15'h1 == st_reg.prog_len && !st_reg.pipe)
              st_next.ready = 1'b1;
          end
        end
        readout_ctrl_pkg::REG_LOG_CFG: begin
          st_next.log_en = i_bus.wdata[readout_ctrl_pkg::LOGCFG_ENABLE];
          st_next.log_src = i_bus.wdata[readout_ctrl_pkg::LOGCFG_SOURCE];
          st_next.log_mode = i_bus.wdata[readout_ctrl_pkg::LOGCFG_MODE];
          if (!i_bus.wdata[readout_ctrl_pkg::LOGCFG_ENABLE])
            st_next.log_state = readout_ctrl_pkg::LOG_IDLE;
        end
        readout_ctrl_pkg::REG_LOG_START: st_next.start_ts = i_bus.wdata[TS_W-1:0];
        readout_ctrl_pkg::REG_LOG_RD_ADDR: st_next.rd_addr = i_bus.wdata[LA-1:0];
        default: ;
      endcase
    end
    // Trigger seen in the same cycle as a reset wins, so none is lost
    if (i_seq_status.triggered)
      st_next.triggered = 1'b1;
    // Logger: tick is the 10 MHz core period, far above 4 ns, so one per cycle
    if (st_reg.log_state != readout_ctrl_pkg::LOG_IDLE)
      st_next.ts = st_reg.ts + TS_W'(readout_ctrl_pkg::TICK_CYCLES);
    unique case (st_reg.log_state)
      readout_ctrl_pkg::LOG_IDLE:
        if (st_reg.log_en && i_seq_start) begin
          st_next.ts = '0;
          st_next.log_state = st_reg.log_mode ? readout_ctrl_pkg::LOG_WAIT
                                              : readout_ctrl_pkg::LOG_NORMAL;
        end
      readout_ctrl_pkg::LOG_NORMAL:
        if (src_vld) begin
          log_we = 1'b1;
          st_next.wptr = st_reg.wptr + 1'b1;
          if (st_reg.count != (LA+1)'(readout_ctrl_pkg::LOG_DEPTH))
            st_next.count = st_reg.count + 1'b1;
        end
      readout_ctrl_pkg::LOG_WAIT:
        if (st_reg.triggered && st_reg.ts >= st_reg.start_ts)
          st_next.log_state = readout_ctrl_pkg::LOG_ACTIVE;
      readout_ctrl_pkg::LOG_ACTIVE:
        if (st_reg.count == (LA+1)'(readout_ctrl_pkg::LOG_DEPTH))
          st_next.log_state = readout_ctrl_pkg::LOG_FULL;
        else if (src_vld) begin
          log_we = 1'b1;
          st_next.wptr = st_reg.wptr + 1'b1;
          st_next.count = st_reg.count + 1'b1;
        end
      readout_ctrl_pkg::LOG_FULL: ;
      default: st_next.log_state = readout_ctrl_pkg::LOG_IDLE;
    endcase
    if (!st_reg.log_en)
      st_next.log_state = readout_ctrl_pkg::LOG_IDLE;
    // Read data, one cycle later
    st_next.rdata = 32'h0;
    if (i_bus.rd) begin
      unique case (a)
        readout_ctrl_pkg::REG_CTRL: begin
          st_next.rdata[readout_ctrl_pkg::CTRL_ENABLE] = st_reg.enable;
          st_next.rdata[readout_ctrl_pkg::CTRL_SINGLE] = st_reg.single;
          st_next.rdata[readout_ctrl_pkg::CTRL_PIPE] = st_reg.pipe;
          st_next.rdata[readout_ctrl_pkg::CTRL_READY] = st_reg.ready;
          st_next.rdata[readout_ctrl_pkg::CTRL_TRIGGERED] = st_reg.triggered;
        end
        readout_ctrl_pkg::REG_DELAY: st_next.rdata = 32'(st_reg.delay);
        readout_ctrl_pkg::REG_VALID_CFG: begin
          st_next.rdata[4:0] = st_reg.vidx;
          st_next.rdata[readout_ctrl_pkg::VPOL_LSB +: 2] = st_reg.vpol;
        end
        readout_ctrl_pkg::REG_PROG_LEN: st_next.rdata = 32'(st_reg.prog_len);
        readout_ctrl_pkg::REG_PROGRESS:
          st_next.rdata = pct(st_reg.prog_cnt, st_reg.prog_len);
        readout_ctrl_pkg::REG_MEM_USAGE:
          st_next.rdata = pct(st_reg.prog_len,
                              15'(readout_ctrl_pkg::IMEM_WORDS));
        readout_ctrl_pkg::REG_SEQ_STATUS: begin
          st_next.rdata[readout_ctrl_pkg::ST_RUNNING] = i_seq_status.running;
          st_next.rdata[readout_ctrl_pkg::ST_WAIT_TRIG] = i_seq_status.wait_trig;
          st_next.rdata[readout_ctrl_pkg::ST_ERROR] = i_seq_status.error;
          st_next.rdata[readout_ctrl_pkg::ST_WAIT_SYNC] = i_seq_status.wait_sync;
        end
        readout_ctrl_pkg::REG_LOG_CFG:
          st_next.rdata[2:0] = {st_reg.log_mode, st_reg.log_src, st_reg.log_en};
        readout_ctrl_pkg::REG_LOG_START: st_next.rdata = 32'(st_reg.start_ts);
        readout_ctrl_pkg::REG_LOG_STATUS:
          st_next.rdata = {5'h0, 11'(st_reg.count), 13'h0, st_reg.log_state};
        readout_ctrl_pkg::REG_LOG_RD_ADDR: st_next.rdata = 32'(st_reg.rd_addr);
        readout_ctrl_pkg::REG_LOG_RD_DATA: st_next.rdata = log_data[st_reg.rd_addr];
        readout_ctrl_pkg::REG_LOG_RD_TIME:
          st_next.rdata = 32'(log_time[st_reg.rd_addr]);
        default:
          if (a[7:6] == 2'h1)
            st_next.rdata = user_reg[a[5:2]];
      endcase
    end
  end

  // ==========================================================================
  // Registers
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  // Sequencer write wins over a host write to the same user register
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      for (int i = 0; i < readout_ctrl_pkg::NUM_USER; i++)
        user_reg[i] <= 32'h0;
    end else begin
      if (i_bus.wr && a[7:6] == 2'h1)
        user_reg[a[5:2]] <= i_bus.wdata;
      if (i_user_we)
        user_reg[i_user_idx] <= i_user_wdata;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (log_we) begin
      log_data[st_reg.wptr] <= log_word;
      log_time[st_reg.wptr] <= st_reg.ts;
    end
  end

  assign o_user_rdata = user_reg[i_user_idx];
  assign o_rdata      = st_reg.rdata;
  assign o_seq_enable = st_reg.enable;
  assign o_seq_single = st_reg.single;
  assign o_seq_ready  = st_reg.ready;
  assign o_clear_wave = st_reg.clear_wave;
  assign o_play_delay = st_reg.delay;
  assign o_prog_we    = st_reg.prog_we;
  assign o_stage_we   = st_reg.stage_we;
  assign o_prog_addr  = st_reg.prog_addr;
  assign o_prog_data  = st_reg.prog_data;

  // ==========================================================================
  // Assertions
  AST_READY_DROP: assert property (@(posedge i_core_clk) disable iff (i_rst)
    i_bus.wr && a == readout_ctrl_pkg::REG_CTRL &&
    i_bus.wdata[readout_ctrl_pkg::CTRL_SEQRESET] |=> !o_seq_ready)
    else $error("ready after reset");
  AST_ENABLE_NEEDS_READY: assert property (@(posedge i_core_clk) disable iff (i_rst)
    o_seq_enable |-> $past(o_seq_ready))
    else $error("enabled without program");
  AST_STAGE_ROUTE: assert property (@(posedge i_core_clk) disable iff (i_rst)
    !(o_prog_we && o_stage_we))
    else $error("both stores written");
  AST_FULL_STOP: assert property (@(posedge i_core_clk) disable iff (i_rst)
    st_reg.log_state == readout_ctrl_pkg::LOG_FULL |-> !log_we)
    else $error("logged while full");
  AST_COUNT_MAX: assert property (@(posedge i_core_clk) disable iff (i_rst)
    st_reg.count <= (LA+1)'(readout_ctrl_pkg::LOG_DEPTH))
    else $error("count overflow");
  AST_RES_BIT: assert property (@(posedge i_core_clk) disable iff (i_rst)
    $past(i_bus.rd) && $past(a) == readout_ctrl_pkg::REG_SEQ_STATUS
    |-> o_rdata[1] == 1'b0)
    else $error("reserved bit set");
  AST_TRIG_STICKY: assert property (@(posedge i_core_clk) disable iff (i_rst)
    i_seq_status.triggered |=> st_reg.triggered)
    else $error("trigger lost");
  AST_CLEAR_PULSE: assert property (@(posedge i_core_clk) disable iff (i_rst)
    o_clear_wave |=> !o_clear_wave)
    else $error("clear longer than one cycle");
  COV_NORMAL: cover property (@(posedge i_core_clk)
    st_reg.log_state == readout_ctrl_pkg::LOG_NORMAL && log_we);
  COV_FULL: cover property (@(posedge i_core_clk)
    st_reg.log_state == readout_ctrl_pkg::LOG_FULL);
  COV_READY: cover property (@(posedge i_core_clk) $rose(o_seq_ready));
endmodule : readout_sequencer_ctrl_logger
`default_nettype wire

// [dv/seq_core_model.sv]
// Behavioural sequencer core driving status, start and link words
`timescale 1ns/100ps
`default_nettype none
module seq_core_model (
  input  wire logic                     i_core_clk,  // Core clock
  input  wire logic                     i_rst,       // Sync high
  input  wire logic                     i_enable,    // Run enable
  input  wire logic                     i_error,     // Error level
  input  wire logic                     i_wait_sync, // Sync wait level
  output readout_ctrl_pkg::seq_status_s o_status,    // Core state
  output logic                          o_start,     // Run pulse
  output logic [31:0]                   o_sync_word, // Link word
  output logic                          o_sync_vld   // Link strobe
);
  logic        en_d;
  logic [2:0]  trig_cnt;
  logic [31:0] tick;
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      en_d <= 1'b0;
      o_start <= 1'b0;
      trig_cnt <= 3'h0;
      tick <= 32'h0;
      o_sync_vld <= 1'b0;
      o_sync_word <= 32'h0;
    end else begin
      en_d <= i_enable;
      o_start <= i_enable & ~en_d;
      tick <= tick + 32'h1;
      trig_cnt <= !i_enable ? 3'h0 : trig_cnt + 3'(trig_cnt != 3'h7);
      o_sync_vld <= i_enable;
      // Idle link alternates the last word with its complement
      o_sync_word <= i_enable ? tick : ~o_sync_word;
    end
  end
  always_comb begin
    o_status = '0;
    o_status.running = en_d;
    o_status.wait_trig = en_d & (trig_cnt < 3'h4);
    o_status.triggered = en_d & (trig_cnt >= 3'h4);
    o_status.error = i_error;
    o_status.wait_sync = i_wait_sync;
  end
endmodule : seq_core_model
`default_nettype wire

// [dv/testbench.sv]
// Self-checking bench for the sequencer control and logger block
`timescale 1ns/100ps
`default_nettype none
module testbench;
  localparam logic [7:0] CT = readout_ctrl_pkg::REG_CTRL;
  localparam logic [7:0] LS = readout_ctrl_pkg::REG_LOG_STATUS;
  localparam logic [7:0] PD = readout_ctrl_pkg::REG_PROG_DATA;
  logic clk = 1'b0;
  logic rst = 1'b1;
  readout_ctrl_pkg::bus_req_s bus = '0;
  readout_ctrl_pkg::seq_status_s st;
  logic [31:0] rdata, urd, pdata, sword, r;
  logic [31:0] dio = 32'h0;
  logic [31:0] uwd = 32'h0;
  logic [3:0]  uidx = 4'h0;
  logic [15:0] dly;
  logic [13:0] paddr;
  logic uwe = 1'b0;
  logic err = 1'b0;
  logic wsync = 1'b0;
  logic en, single, ready, clrw, prog_we, stage_we, dvld, start, svld;
  int failures = 0;
  int checks = 0;
  int seed = 32'hA9A7;
  int exp_user[16];
  always #50 clk = ~clk;
  readout_sequencer_ctrl_logger readout_sequencer_ctrl_logger_inst (
    .i_core_clk(clk), .i_rst(rst), .i_bus(bus), .o_rdata(rdata),
    .i_dio(dio), .i_sync_word(sword), .i_sync_vld(svld),
    .i_seq_status(st), .i_seq_start(start), .i_user_we(uwe),
    .i_user_idx(uidx), .i_user_wdata(uwd), .o_user_rdata(urd),
    .o_seq_enable(en), .o_seq_single(single), .o_seq_ready(ready),
    .o_clear_wave(clrw), .o_play_delay(dly), .o_prog_we(prog_we),
    .o_stage_we(stage_we), .o_prog_addr(paddr), .o_prog_data(pdata),
    .o_dio_valid(dvld));
  seq_core_model seq_core_model_inst (
    .i_core_clk(clk), .i_rst(rst), .i_enable(en), .i_error(err),
    .i_wait_sync(wsync), .o_status(st), .o_start(start),
    .o_sync_word(sword), .o_sync_vld(svld));
  task automatic cmp(string n, logic [31:0] e, logic [31:0] g);
    checks++;
    if (g !== e) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask : cmp
  task automatic wr(logic [7:0] a, logic [31:0] d);
    @(posedge clk);
    bus.addr <= a;
    bus.wdata <= d;
    bus.wr <= 1'b1;
    @(posedge clk);
    bus.wr <= 1'b0;
  endtask : wr
  task automatic rd(logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    bus.addr <= a;
    bus.rd <= 1'b1;
    @(posedge clk);
    bus.rd <= 1'b0;
    @(negedge clk);
    d = rdata;
  endtask : rd
  task automatic rd_chk(string n, logic [7:0] a, logic [31:0] e);
    logic [31:0] d;
    rd(a, d);
    cmp(n, e, d);
  endtask : rd_chk
  task automatic results;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : results
  // ==========================================
  // Watchdog sized well above the longest log wait
  initial begin
    repeat (40000) @(posedge clk);
    failures++;
    results();
  end
  // ==========================================
  // Main sequence
  initial begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    rd_chk("ctrl", CT, 32'h0);
    wr(CT, 32'h8);
    @(negedge clk);
    cmp("clear_wave", 32'h1, 32'(clrw));
    @(negedge clk);
    cmp("clear_wave", 32'h0, 32'(clrw));
    r = $random(seed);
    wr(readout_ctrl_pkg::REG_DELAY, r);
    @(negedge clk);
    cmp("delay", 32'(r[15:0]), 32'(dly));
    for (int p = 0; p < 4; p++) begin
      @(posedge clk);
      r = $random(seed);
      dio <= $random(seed);
      wr(readout_ctrl_pkg::REG_VALID_CFG, {22'h0, p[1:0], 3'h0, r[4:0]});
      repeat (4) @(negedge clk);
      cmp("dio_valid", 32'(p == 3 || p == 0 || (p == 2) == dio[r[4:0]]),
          32'(dvld));
    end
    // 164 words so usage rounds to one percent either way
    wr(readout_ctrl_pkg::REG_PROG_LEN, 32'hA4);
    for (int i = 0; i < 165; i++) begin
      r = $random(seed);
      wr(PD, r);
      @(negedge clk);
      cmp("prog_we", 32'(i < 164), 32'(prog_we));
      if (i < 164) begin
        cmp("prog_addr", i, 32'(paddr));
        cmp("prog_data", r, pdata);
      end
    end
    cmp("ready", 32'h1, 32'(ready));
    wr(readout_ctrl_pkg::REG_PROGRESS, 32'h0);
    rd_chk("progress", readout_ctrl_pkg::REG_PROGRESS, 32'h64);
    rd_chk("usage", readout_ctrl_pkg::REG_MEM_USAGE, 32'h1);
    for (int i = 0; i < 16; i++) begin
      exp_user[i] = $random(seed);
      wr(8'h40 + 8'(4 * i), exp_user[i]);
    end
    @(posedge clk);
    exp_user[5] = $random(seed);
    uwe <= 1'b1;
    uidx <= 4'h5;
    uwd <= exp_user[5];
    @(posedge clk);
    uwe <= 1'b0;
    for (int i = 0; i < 16; i++) begin
      @(posedge clk);
      uidx <= 4'(i);
      rd_chk("user_host", 8'h40 + 8'(4 * i), exp_user[i]);
      cmp("user_seq", exp_user[i], urd);
    end
    wr(readout_ctrl_pkg::REG_LOG_CFG, 32'h3);
    wr(CT, 32'h3);
    @(negedge clk);
    cmp("enable", 32'h1, 32'(en));
    cmp("single", 32'h1, 32'(single));
    repeat (1100) @(posedge clk);
    rd_chk("log", LS, {5'h0, 11'h400, 13'h0, 3'h1});
    r = $random(seed);
    @(posedge clk);
    err <= r[0];
    wsync <= r[1];
    repeat (3) @(posedge clk);
    rd_chk("status", readout_ctrl_pkg::REG_SEQ_STATUS,
           {27'h0, r[1], r[0], 3'h1});
    rd(CT, r);
    cmp("ready_trig", 32'h3, 32'(r[9:8]));
    wr(CT, 32'h10);
    @(negedge clk);
    cmp("ready", 32'h0, 32'(ready));
    // Core trigger level lingers one cycle after enable drops
    repeat (2) @(posedge clk);
    wr(CT, 32'h10);
    rd(CT, r);
    cmp("ready_trig", 32'h0, 32'(r[9:8]));
    wr(CT, 32'h1);
    @(negedge clk);
    cmp("enable", 32'h0, 32'(en));
    wr(CT, 32'h4);
    wr(readout_ctrl_pkg::REG_PROG_LEN, 32'h1);
    wr(PD, 32'h5A5A);
    @(negedge clk);
    cmp("stage_we", 32'h1, 32'(stage_we));
    cmp("prog_we", 32'h0, 32'(prog_we));
    wr(CT, 32'h10);
    wr(CT, 32'h0);
    wr(readout_ctrl_pkg::REG_PROG_LEN, 32'h1);
    wr(PD, 32'h5A5A);
    wr(CT, 32'h20);
    rd(LS, r);
    cmp("log_count", 32'h0, 32'(r[26:16]));
    wr(readout_ctrl_pkg::REG_LOG_CFG, 32'h0);
    wr(readout_ctrl_pkg::REG_LOG_CFG, 32'h7);
    wr(readout_ctrl_pkg::REG_LOG_START, 32'h3000);
    wr(CT, 32'h1);
    repeat (20) @(posedge clk);
    rd_chk("log", LS, 32'h2);
    for (int i = 0; i < 8000 && r[2:0] != 3'h3; i++) rd(LS, r);
    cmp("log_state", 32'h3, 32'(r[2:0]));
    for (int i = 0; i < 1000 && r[2:0] == 3'h3; i++) rd(LS, r);
    cmp("log", {5'h0, 11'h400, 13'h0, 3'h4}, r);
    results();
  end
endmodule : testbench
`default_nettype wire
